// ---- logic/atcc_core.sv ----
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// counting core: clock source select, prescaler, up/down counter, repeat and update
module atcc_core #(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  // register port
  input  wire logic [3:0]       i_addr,
  input  wire logic [15:0]      i_wr_data,
  input  wire logic             i_wr_stb,
  input  wire logic             i_rd_stb,
  output logic      [15:0]      o_rd_data,
  // clock sources from outside the kernel domain
  input  wire logic [3:0]       i_internal_trigger_inputs,
  input  wire logic [3:0]       i_channel_pin,
  input  wire logic [3:0]       i_multi_channel_pin,
  input  wire logic             i_ext_trigger_input,
  // counter state and events
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_overflow,
  output logic                  o_underflow,
  output logic                  o_update
);

  // software-visible control
  logic             run_r;
  logic             inhibit_r;
  logic             dir_down_r;
  logic [2:0]       slave_mode_select_r;
  logic [3:0]       trigger_source_select_r;
  logic             pin_fall_r;
  logic             ext_clock_mode1_enable_r;
  // preload and shadow registers
  logic [CNT_W-1:0] presc_pre_r;
  logic [CNT_W-1:0] presc_sh_r;
  logic [CNT_W-1:0] reload_pre_r;
  logic [CNT_W-1:0] reload_sh_r;
  logic [REP_W-1:0] repeat_pre_r;
  logic [REP_W-1:0] repeat_sh_r;
  // running state
  logic [CNT_W-1:0] presc_cnt_r;
  logic [CNT_W-1:0] count_r;
  logic [REP_W-1:0] rep_cnt_r;
  logic [15:0]      rd_data_r;
  logic             overflow_r;
  logic             underflow_r;
  logic             update_r;

  // synchronised edges of all external sources
  logic [12:0] src_rise;
  logic [12:0] src_fall;
  logic [3:0]  trig_rise;
  logic [7:0]  pin_rise;
  logic [7:0]  pin_fall;
  logic [7:0]  pin_edge;
  logic        ci0_both;
  logic        ext_rise;

  // decoded strobes and events
  logic wr_ctrl;
  logic wr_slave;
  logic wr_count;
  // soft_go beats every other counter source in the same cycle
  logic soft_go;
  logic ext_sel;
  logic ext_trig_sel;
  logic trg_pulse;
  logic src_pulse;
  logic presc_expire;
  logic tick;
  logic up_wrap;
  logic down_wrap;
  logic wrap;
  logic rep_zero;
  logic upd_go;

  // all external levels share one synchroniser bank
  atcc_edge_sync #(
    .WIDTH (13)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_ext_trigger_input, i_multi_channel_pin, i_channel_pin,
                 i_internal_trigger_inputs}),
    .o_rise    (src_rise),
    .o_fall    (src_fall)
  );

  // split the edge vector; external trigger is already one pin picked outside
  assign trig_rise = src_rise[3:0];
  assign pin_rise  = src_rise[11:4];
  assign pin_fall  = src_fall[11:4];
  assign ext_rise  = src_rise[12];
  // every source pulse is one kernel cycle wide, so no edge is counted twice
  assign ci0_both = src_rise[4] | src_fall[4];
  // channel pins on sources 5, 6 and 8-13 use the polarity chosen by software; source 4 takes both edges of pin 0
  assign pin_edge = pin_fall_r ? pin_fall : pin_rise;

  // register port decode
  assign wr_ctrl  = i_wr_stb && (i_addr == atcc_pkg::ATCC_ADDR_CTRL);
  assign wr_slave = i_wr_stb && (i_addr == atcc_pkg::ATCC_ADDR_SLAVE);
  assign wr_count = i_wr_stb && (i_addr == atcc_pkg::ATCC_ADDR_COUNT);
  // a soft request is a write with its bit set; the other bits of that word are ignored
  assign soft_go  = i_wr_stb && (i_addr == atcc_pkg::ATCC_ADDR_EVENT)
                    && i_wr_data[atcc_pkg::ATCC_SOFT_UPD_BIT];

  // external source chosen by slave modes 1,2,3,7 or the mode-1 bit
  // modes 4, 5 and 6 fall through to the kernel clock
  assign ext_sel = ext_clock_mode1_enable_r
                   || (slave_mode_select_r != atcc_pkg::ATCC_MODE_INTERNAL
                       && slave_mode_select_r[2] == 1'b0)
                   || (slave_mode_select_r == atcc_pkg::ATCC_MODE_EXTCLK0);
  // filtered external trigger wins through the mode-1 bit or source 7
  assign ext_trig_sel = ext_clock_mode1_enable_r
                        || (trigger_source_select_r == atcc_pkg::ATCC_SRC_EXT_TRIG);

  // trigger source multiplexer
  // codes E and F are spare: they pick nothing, so the prescaler stands still
  // rather than silently falling back to the kernel clock
  always_comb
  begin
    trg_pulse = 1'b0;
    unique case (trigger_source_select_r)
      4'h0, 4'h1, 4'h2, 4'h3: trg_pulse = trig_rise[trigger_source_select_r[1:0]];
      4'h4:                   trg_pulse = ci0_both;
      4'h5:                   trg_pulse = pin_edge[0];
      4'h6:                   trg_pulse = pin_edge[1];
      4'h7:                   trg_pulse = ext_rise;
      4'h8:                   trg_pulse = pin_edge[2];
      4'h9:                   trg_pulse = pin_edge[3];
      4'hA:                   trg_pulse = pin_edge[4];
      4'hB:                   trg_pulse = pin_edge[5];
      4'hC:                   trg_pulse = pin_edge[6];
      4'hD:                   trg_pulse = pin_edge[7];
      4'hE, 4'hF:             trg_pulse = 1'b0;
    endcase
  end

  // kernel clock counts every cycle unless an external source is selected
  always_comb
  begin
    if (!ext_sel)
      src_pulse = 1'b1;
    else if (ext_trig_sel)
      src_pulse = ext_rise;
    else
      src_pulse = trg_pulse;
  end

  // prescaler expires after shadow value plus one source pulses
  // >= rather than == so a lowered shadow value cannot strand the divider
  assign presc_expire = (presc_cnt_r >= presc_sh_r);
  assign tick         = run_r && src_pulse && presc_expire;

  // wrap conditions inside the active reload range
  assign up_wrap   = tick && !dir_down_r && (count_r >= reload_sh_r);
  assign down_wrap = tick && dir_down_r && (count_r == '0);
  assign wrap      = up_wrap || down_wrap;
  assign rep_zero  = (rep_cnt_r == '0);

  // update from software or from the last repeated wrap, unless inhibited
  // an inhibited soft request still restarts the counters; only the update is lost
  assign upd_go = !inhibit_r && (soft_go || (wrap && rep_zero));

  // control register; direction is owned by software
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      run_r      <= 1'b0;
      inhibit_r  <= 1'b0;
      dir_down_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      run_r      <= i_wr_data[atcc_pkg::ATCC_CTRL_RUN_BIT];
      inhibit_r  <= i_wr_data[atcc_pkg::ATCC_CTRL_INHIBIT_BIT];
      dir_down_r <= i_wr_data[atcc_pkg::ATCC_CTRL_DIR_BIT];
    end
  end

  // slave mode configuration
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      slave_mode_select_r      <= atcc_pkg::ATCC_MODE_INTERNAL;
      trigger_source_select_r  <= 4'h0;
      pin_fall_r               <= 1'b0;
      ext_clock_mode1_enable_r <= 1'b0;
    end
    else if (wr_slave)
    begin
      slave_mode_select_r      <= i_wr_data[atcc_pkg::ATCC_MODE_LSB +: 3];
      trigger_source_select_r  <= i_wr_data[atcc_pkg::ATCC_SRC_LSB +: 4];
      pin_fall_r               <= i_wr_data[atcc_pkg::ATCC_PIN_FALL_BIT];
      ext_clock_mode1_enable_r <= i_wr_data[atcc_pkg::ATCC_ECM1_BIT];
    end
  end

  // preload registers take software writes at once
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      presc_pre_r  <= atcc_pkg::ATCC_PRESC_RST;
      reload_pre_r <= atcc_pkg::ATCC_RELOAD_RST;
      repeat_pre_r <= atcc_pkg::ATCC_REPEAT_RST;
    end
    else if (i_wr_stb)
    begin
      if (i_addr == atcc_pkg::ATCC_ADDR_PRESC)
        presc_pre_r <= i_wr_data[CNT_W-1:0];   // held back until update
      if (i_addr == atcc_pkg::ATCC_ADDR_RELOAD)
        reload_pre_r <= i_wr_data[CNT_W-1:0];
      if (i_addr == atcc_pkg::ATCC_ADDR_REPEAT)
        repeat_pre_r <= i_wr_data[REP_W-1:0];
    end
  end

  // shadows change only on an update event, so a period never runs half old, half new
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      presc_sh_r  <= atcc_pkg::ATCC_PRESC_RST;
      reload_sh_r <= atcc_pkg::ATCC_RELOAD_RST;
      repeat_sh_r <= atcc_pkg::ATCC_REPEAT_RST;
    end
    else if (upd_go)
    begin
      // an inhibited update leaves all three shadows as they were
      presc_sh_r  <= presc_pre_r;
      reload_sh_r <= reload_pre_r;
      repeat_sh_r <= repeat_pre_r;
    end
  end

  // prescaler counter; a soft update restarts the division
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    // the count returns to zero on expiry, so it never outgrows the shadow width
    if (!i_reset_n)
      presc_cnt_r <= '0;
    else if (soft_go)
      presc_cnt_r <= '0;
    else if (run_r && src_pulse)
      presc_cnt_r <= presc_expire ? '0 : presc_cnt_r + 1'b1;
  end

  // main counter; soft request and software write beat a tick in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      count_r <= atcc_pkg::ATCC_COUNT_RST;
    // down mode takes the preload, so the new period starts at once
    else if (soft_go)
      count_r <= dir_down_r ? reload_pre_r : '0;
    else if (wr_count)
      count_r <= i_wr_data[CNT_W-1:0];
    else if (up_wrap)
      count_r <= '0;
    else if (down_wrap)
      count_r <= reload_sh_r;
    else if (tick)
      count_r <= dir_down_r ? count_r - 1'b1 : count_r + 1'b1;
  end

  // repeat counter steps down per wrap and restarts at zero
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rep_cnt_r <= atcc_pkg::ATCC_REPEAT_RST;
    // a soft request restarts the repeat run even while updates are inhibited
    else if (soft_go)
      rep_cnt_r <= repeat_pre_r;
    else if (wrap && rep_zero)
      rep_cnt_r <= upd_go ? repeat_pre_r : repeat_sh_r;
    else if (wrap)
      rep_cnt_r <= rep_cnt_r - 1'b1;
  end

  // event outputs, one cycle after the wrap or request that caused them
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      overflow_r  <= 1'b0;
      underflow_r <= 1'b0;
      update_r    <= 1'b0;
    end
    else
    begin
      overflow_r  <= up_wrap;
      underflow_r <= down_wrap;
      update_r    <= upd_go;
    end
  end

  // read data register; loaded on the read strobe and held until the next read strobe
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rd_data_r <= 16'h0000;
    else if (i_rd_stb)
    begin
      rd_data_r <= 16'h0000;
      unique case (i_addr)
        atcc_pkg::ATCC_ADDR_CTRL:
        begin
          rd_data_r[atcc_pkg::ATCC_CTRL_RUN_BIT]     <= run_r;
          rd_data_r[atcc_pkg::ATCC_CTRL_INHIBIT_BIT] <= inhibit_r;
          rd_data_r[atcc_pkg::ATCC_CTRL_DIR_BIT]     <= dir_down_r;
        end
        atcc_pkg::ATCC_ADDR_SLAVE:
        begin
          rd_data_r[atcc_pkg::ATCC_MODE_LSB +: 3]   <= slave_mode_select_r;
          rd_data_r[atcc_pkg::ATCC_SRC_LSB +: 4]    <= trigger_source_select_r;
          rd_data_r[atcc_pkg::ATCC_PIN_FALL_BIT]    <= pin_fall_r;
          rd_data_r[atcc_pkg::ATCC_ECM1_BIT]        <= ext_clock_mode1_enable_r;
        end
        atcc_pkg::ATCC_ADDR_COUNT:  rd_data_r[CNT_W-1:0] <= count_r;
        atcc_pkg::ATCC_ADDR_PRESC:  rd_data_r[CNT_W-1:0] <= presc_pre_r;
        atcc_pkg::ATCC_ADDR_RELOAD: rd_data_r[CNT_W-1:0] <= reload_pre_r;
        atcc_pkg::ATCC_ADDR_REPEAT: rd_data_r[REP_W-1:0] <= repeat_pre_r;
        atcc_pkg::ATCC_ADDR_STATUS: rd_data_r[REP_W-1:0] <= rep_cnt_r;
        default:                    rd_data_r <= 16'h0000; // event reg and unmapped read zero
      endcase
    end
  end

  // outputs straight from flops
  assign o_rd_data   = rd_data_r;
  assign o_count     = count_r;
  assign o_overflow  = overflow_r;
  assign o_underflow = underflow_r;
  assign o_update    = update_r;

endmodule
`default_nettype wire

// ---- logic/atcc_edge_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser per bit followed by a rise/fall detector
module atcc_edge_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  // asynchronous levels in
  input  wire logic [WIDTH-1:0] i_async,
  // edge pulses out, one kernel cycle each
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] last_r;

  // meta_r feeds only sync_r; edges are taken after the second flop
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // one pulse per edge of the synchronised level
  assign o_rise = sync_r & ~last_r;
  assign o_fall = ~sync_r & last_r;

endmodule
`default_nettype wire

// ---- logic/atcc_pkg.sv ----
// Summary of operation
// - main counter is a 16-bit unsigned value wrapping inside the reload range
// - slave mode 0 counts kernel clock; dividing runs only while run bit is set
// - slave modes 1,2,3,7 use the trigger source; 4,5,6 use kernel clock
// - mode 7 with sources 4-6 and 8-13 counts chosen channel pin edges
// - mode 7 with sources 0-3 counts rising edges of internal triggers
// - mode-1 enable bit, or mode 7 with source 7, selects filtered external trigger
// - one prescaler pulse per rising edge of the filtered external trigger
// - external trigger arrives from one of three pins, picked outside this block
// - prescaler divides by programmed value plus one, 1 to 65536
// - written prescaler value waits in preload until the next update event
// - up mode counts 0 to reload, then restarts at 0 with overflow
// - up mode raises update only after repeat count plus one overflows
// - up mode soft update request clears counter and raises update
// - update inhibit bit suppresses update events
// - each update copies repeat, reload and prescaler preloads into shadows
// - down mode counts reload to 0, then reloads with underflow
// - down mode raises update only after repeat count plus one underflows
// - down mode soft update request loads reload value and raises update
// - repeat counter steps down on each overflow or underflow
// - soft update request also reloads repeat counter from programmed value
package atcc_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ATCC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ATCC_ADDR_SLAVE  = 4'h1;
  localparam logic [3:0] ATCC_ADDR_EVENT  = 4'h2;
  localparam logic [3:0] ATCC_ADDR_COUNT  = 4'h3;
  localparam logic [3:0] ATCC_ADDR_PRESC  = 4'h4;
  localparam logic [3:0] ATCC_ADDR_RELOAD = 4'h5;
  localparam logic [3:0] ATCC_ADDR_REPEAT = 4'h6;
  localparam logic [3:0] ATCC_ADDR_STATUS = 4'h7;

  // control_reg0 fields
  localparam int ATCC_CTRL_RUN_BIT     = 0;
  localparam int ATCC_CTRL_INHIBIT_BIT = 1;
  localparam int ATCC_CTRL_DIR_BIT     = 4;

  // slave_mode_cfg_reg fields
  localparam int ATCC_MODE_LSB     = 0;
  localparam int ATCC_SRC_LSB      = 4;
  localparam int ATCC_PIN_FALL_BIT = 8;
  localparam int ATCC_ECM1_BIT     = 14;

  // software_event_reg field
  localparam int ATCC_SOFT_UPD_BIT = 0;

  // reset values
  localparam logic [15:0] ATCC_COUNT_RST  = 16'h0000;
  localparam logic [15:0] ATCC_PRESC_RST  = 16'h0000;
  localparam logic [15:0] ATCC_RELOAD_RST = 16'hFFFF;
  localparam logic [7:0]  ATCC_REPEAT_RST = 8'h00;

  // slave mode select codes
  localparam logic [2:0] ATCC_MODE_INTERNAL = 3'h0;
  localparam logic [2:0] ATCC_MODE_EXTCLK0  = 3'h7;

  // trigger source select codes with special meaning
  localparam logic [3:0] ATCC_SRC_TRIG_LAST = 4'h3;
  localparam logic [3:0] ATCC_SRC_CH0_BOTH  = 4'h4;
  localparam logic [3:0] ATCC_SRC_EXT_TRIG  = 4'h7;

endpackage

// ---- tb/advanced_timer_counter_core_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module advanced_timer_counter_core_bench;
  logic        clk, rst_n, wr_stb, rd_stb, go, busy, ovf, udf, upd, ext;
  logic [3:0]  addr, line, hold, trig, chan, mch;
  logic [15:0] wdata, rd_data, count, v, n;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  // source rows: config word, pulsed line, count after two pulses (FFFF: kernel rate)
  logic [35:0] rows [20] = '{
    {16'h0007, 4'h0, 16'h0002}, {16'h0017, 4'h1, 16'h0002}, {16'h0027, 4'h2, 16'h0002},
    {16'h0037, 4'h3, 16'h0002}, {16'h0047, 4'h4, 16'h0004}, {16'h0057, 4'h4, 16'h0002},
    {16'h0067, 4'h5, 16'h0002}, {16'h0187, 4'h6, 16'h0002}, {16'h0097, 4'h7, 16'h0002},
    {16'h00A7, 4'h8, 16'h0002}, {16'h00B7, 4'h9, 16'h0002}, {16'h00C7, 4'hA, 16'h0002},
    {16'h00D7, 4'hB, 16'h0002}, {16'h0077, 4'hC, 16'h0002}, {16'h4000, 4'hC, 16'h0002},
    {16'h0011, 4'h1, 16'h0002}, {16'h0007, 4'h1, 16'h0000}, {16'h00E7, 4'h0, 16'h0000},
    {16'h0004, 4'h0, 16'hFFFF}, {16'h0000, 4'h0, 16'hFFFF}};
  atcc_core dut_u (.i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rd_data),
    .i_internal_trigger_inputs(trig), .i_channel_pin(chan), .i_multi_channel_pin(mch),
    .i_ext_trigger_input(ext), .o_count(count), .o_overflow(ovf), .o_underflow(udf),
    .o_update(upd));
  atcc_src_model src_u (.i_ref_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_line(line),
    .i_hold(hold), .o_trig(trig), .o_chan(chan), .o_mch(mch), .o_ext(ext), .o_busy(busy));
  // free-running kernel clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    check_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // read data are taken in the one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rd_data;
  endtask
  task automatic pulse(input logic [3:0] l);
    @(posedge clk);
    while (busy !== 1'b0)
      @(posedge clk);
    go   <= 1'b1;
    line <= l;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // cycles between two pulses of an event; 400 means none seen
  task automatic gap(input int w, output logic [15:0] g);
    for (int p = 0; p < 2; p++)
    begin
      g = 16'h0000;
      do
      begin
        @(posedge clk);
        g++;
      end
      while ((w == 0 ? ovf : w == 1 ? udf : upd) !== 1'b1 && g < 16'h0190);
    end
  endtask
  // ceiling well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    {rst_n, wr_stb, rd_stb, go} = 4'h0;
    {addr, line, hold, wdata} = 28'h0000000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++)
    begin
      rd(a[3:0], v);
      check(v, a == 5 ? atcc_pkg::ATCC_RELOAD_RST : 16'h0000, "reset or unmapped read");
    end
    $display("test reset values done");
    for (int i = 0; i < 20; i++)
    begin
      hold <= i[0] ? 4'h8 : 4'h3;
      wr(4'h0, 16'h0000);
      wr(4'h3, 16'h0000);
      wr(4'h1, rows[i][35:20]);
      wr(4'h0, 16'h0001);
      pulse(rows[i][19:16]);
      pulse(rows[i][19:16]);
      pulse(4'hD);
      repeat (6) @(posedge clk);
      wr(4'h0, 16'h0000);
      rd(4'h3, v);
      if (rows[i][15:0] == 16'hFFFF)
        check({15'h0000, v > 16'h0010}, 16'h0001, "kernel rate count");
      else
        check(v, rows[i][15:0], "source row count");
    end
    $display("test clock sources done");
    wr(4'h1, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0002);
    wr(4'h6, 16'h0001);
    wr(4'h2, 16'h0001);
    wr(4'h0, 16'h0001); // up counting
    gap(0, n);
    check(n, 16'h0003, "overflow spacing");
    gap(2, n);
    check(n, 16'h0006, "update spacing");
    wr(4'h0, 16'h0003);
    wr(4'h4, 16'h0002);
    gap(0, n);
    check(n, 16'h0003, "prescaler held in preload");
    gap(2, n);
    check(n, 16'h0190, "update while inhibited");
    wr(4'h0, 16'h0001);
    gap(2, n);
    check(n, 16'h0012, "update spacing after reload");
    gap(0, n);
    check(n, 16'h0009, "overflow spacing divided by three");
    $display("test up counting done");
    wr(4'h0, 16'h0011); // down counting
    wr(4'h4, 16'h0000);
    wr(4'h2, 16'h0001);
    gap(1, n);
    check(n, 16'h0003, "underflow spacing");
    gap(2, n);
    check(n, 16'h0006, "down update spacing");
    wr(4'h0, 16'h0010);
    wr(4'h5, 16'h0007);
    wr(4'h6, 16'h0003);
    wr(4'h2, 16'h0001);
    rd(4'h3, v);
    check(v, 16'h0007, "down soft request count");
    rd(4'h7, v);
    check(v, 16'h0003, "repeat counter reloaded");
    wr(4'h0, 16'h0000);
    wr(4'h3, 16'h0005);
    wr(4'h2, 16'h0001);
    rd(4'h3, v);
    check(v, 16'h0000, "up soft request count");
    $display("test soft requests done");
    wr(4'h0, 16'h0001);
    repeat (5) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h3, v);
    check(v, atcc_pkg::ATCC_COUNT_RST, "count after second reset");
    rd(4'h5, v);
    check(v, atcc_pkg::ATCC_RELOAD_RST, "reload after second reset");
    $display("test mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire

// ---- tb/atcc_core_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// port-level checks; event pulses are judged against the count history
module atcc_core_monitor #(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
) (
  // clock and reset
  input wire logic             i_ref_clk,
  input wire logic             i_reset_n,
  // register port
  input wire logic [3:0]       i_addr,
  input wire logic [15:0]      i_wr_data,
  input wire logic             i_wr_stb,
  input wire logic             i_rd_stb,
  input wire logic [15:0]      o_rd_data,
  // clock sources
  input wire logic [3:0]       i_internal_trigger_inputs,
  input wire logic [3:0]       i_channel_pin,
  input wire logic [3:0]       i_multi_channel_pin,
  input wire logic             i_ext_trigger_input,
  // counter and events
  input wire logic [CNT_W-1:0] o_count,
  input wire logic             o_overflow,
  input wire logic             o_underflow,
  input wire logic             o_update
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic inh_r;
  logic dir_r;
  logic soft_r;
  // software view of inhibit and direction; ports alone cannot show them
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      inh_r  <= 1'b0;
      dir_r  <= 1'b0;
      soft_r <= 1'b0;
    end
    else
    begin
      soft_r <= i_wr_stb && i_addr == 4'h2 && i_wr_data[0];
      if (i_wr_stb && i_addr == 4'h0)
      begin
        inh_r <= i_wr_data[1];
        dir_r <= i_wr_data[4];
      end
    end
  end
  // bus steps that start a behaviour
  sequence s_soft_req;
    i_wr_stb && i_addr == 4'h2 && i_wr_data[0];
  endsequence
  sequence s_count_rd;
    i_rd_stb && !i_wr_stb && i_addr == 4'h3;
  endsequence
  a_ovf_at_wrap: assert property (o_overflow |-> o_count == '0 || $past(o_count) == '0)
    else $error("overflow away from a wrap to zero");
  a_udf_at_wrap: assert property (o_underflow |-> $past(o_count) == '0 || $past(o_count, 2) == '0)
    else $error("underflow away from a wrap at zero");
  a_events_apart: assert property (!(o_overflow && o_underflow))
    else $error("overflow and underflow together");
  a_update_cause: assert property (o_update |-> o_overflow || o_underflow || soft_r || $past(soft_r))
    else $error("update without wrap or request");
  a_soft_update: assert property (s_soft_req ##0 !inh_r |-> ##[1:2] o_update)
    else $error("soft request gave no update");
  a_soft_clear: assert property (s_soft_req ##0 !dir_r |=> o_count == '0)
    else $error("soft request in up mode left count");
  a_inhibit_quiet: assert property (inh_r && $past(inh_r) && $past(inh_r, 2) |-> !o_update)
    else $error("update while inhibited");
  a_step_one: assert property ($changed(o_count) && !$past(i_wr_stb) |->
    o_count == $past(o_count) + 1'b1 || o_count == $past(o_count) - 1'b1 ||
    o_count == '0 || $past(o_count) == '0)
    else $error("count moved by more than one");
  a_count_read: assert property (s_count_rd |=> o_rd_data == $past(o_count))
    else $error("count read back wrong");
  a_rd_hold: assert property (!$past(i_rd_stb) |-> $stable(o_rd_data))
    else $error("read data moved without a read");
endmodule
bind atcc_core atcc_core_monitor #(.CNT_W(CNT_W), .REP_W(REP_W)) mon_u (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
  .i_internal_trigger_inputs(i_internal_trigger_inputs), .i_channel_pin(i_channel_pin),
  .i_multi_channel_pin(i_multi_channel_pin), .i_ext_trigger_input(i_ext_trigger_input),
  .o_count(o_count), .o_overflow(o_overflow), .o_underflow(o_underflow), .o_update(o_update)
);
`default_nettype wire

// ---- tb/atcc_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// far-side source: one full pulse on a chosen line per request, slow or prompt
module atcc_src_model (
  // clock, reset and request
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_go,
  input  wire logic [3:0] i_line,
  input  wire logic [3:0] i_hold,
  // lines into the timer
  output logic      [3:0] o_trig,
  output logic      [3:0] o_chan,
  output logic      [3:0] o_mch,
  output logic            o_ext,
  output logic            o_busy
);
  logic [12:0] lvl_r;
  logic [3:0]  sel_r;
  logic [3:0]  cnt_r;
  logic [1:0]  ph_r;
  // each level stands hold+1 cycles, long enough for a two-flop input stage
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lvl_r <= 13'h0000;
      sel_r <= 4'h0;
      cnt_r <= 4'h0;
      ph_r  <= 2'h0;
    end
    else if (ph_r == 2'h0)
    begin
      if (i_go)
      begin
        lvl_r[i_line] <= 1'b1;
        sel_r         <= i_line;
        cnt_r         <= i_hold;
        ph_r          <= 2'h1;
      end
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    else
    begin
      if (ph_r == 2'h1)
        lvl_r[sel_r] <= 1'b0;
      cnt_r <= i_hold;
      ph_r  <= (ph_r == 2'h1) ? 2'h2 : 2'h0;
    end
  end
  // one external trigger line, already picked outside the timer
  assign o_trig = lvl_r[3:0];
  assign o_chan = lvl_r[7:4];
  assign o_mch  = lvl_r[11:8];
  assign o_ext  = lvl_r[12];
  assign o_busy = (ph_r != 2'h0);
endmodule
`default_nettype wire
